// ==== core/bdsr_serial_regs.sv ====
// module: serial slave and register set of the full-bridge gate driver
//
// Functional notes
// - shift serial_in on rising shift clock, selected
// - deselected: shift clock ignored, register unchanged
// - serial output released while deselected
// - commit word when select rises after sixteen
// - wrong nonzero edge count: discard, set error flag
// - error flag cleared by valid write only
// - first four bits address sixteen registers
// - direction one writes ten data bits
// - direction zero reads, writes nothing
// - last bit gives odd parity, generated
// - read data msb first, advance falling
// - fault summary shown as select falls
// - write to read-only: status out, reset
// - read of read-only register then clears
// - status top five first; writes show status
// - bridge timing: verify time, dead time
// - monitor a: overcurrent, low-side thresholds
// - monitor b: qualifiers, disconnect, high-side
// - monitor c: openload threshold, vds time
// - monitor d: enables, selects, phase ratio
// - mask disables diagnostic; reports clear read
// - control: gates, bootstrap, short, diag pin
`timescale 1ns/1ns
module bdsr_serial_regs (
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                shift_clk_in,
  input  wire logic                chip_select_n_in,
  input  wire logic                serial_in_in,
  input  wire bdsr_pkg::bdsr_mon_s monitor_in,
  output logic                     serial_out_out,
  output logic                     serial_out_en_out,
  output logic                     transfer_error_flag_out,
  output bdsr_pkg::bdsr_timing_s   timing_cfg_out,
  output bdsr_pkg::bdsr_mon_a_s    mon_a_cfg_out,
  output bdsr_pkg::bdsr_mon_b_s    mon_b_cfg_out,
  output bdsr_pkg::bdsr_mon_c_s    mon_c_cfg_out,
  output bdsr_pkg::bdsr_mon_d_s    mon_d_cfg_out,
  output bdsr_pkg::bdsr_sense_s    sense_cfg_out,
  output bdsr_pkg::bdsr_data_t     verify_cmd_system_out,
  output bdsr_pkg::bdsr_data_t     verify_cmd_bridge_out,
  output bdsr_pkg::bdsr_ctrl_s     bridge_ctrl_out
);
  import bdsr_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_COMMIT = 3'b100
  } bdsr_state_e;

  function automatic logic [5:0] gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
  // ------------------------------------------------------------------
  // link domain: shift register and edge counters
  // ------------------------------------------------------------------
  logic                link_rst_q;
  logic [15:0]         rx_q;
  logic [5:0]          rcnt_q;
  logic [5:0]          fcnt_q;
  logic [5:0]          fgray_q;
  logic [5:0]          fcnt_nx;

  // link clock stands still outside frames, so its reset is asynchronous
  always_ff @(posedge clk_in) begin
    link_rst_q <= sys_rst_in;
  end

  always_ff @(posedge shift_clk_in or posedge link_rst_q) begin
    if (link_rst_q) begin
      rx_q   <= '0;
      rcnt_q <= '0;
    end else if (!chip_select_n_in) begin
      rx_q   <= {rx_q[WORD_BITS-2:0], serial_in_in};
      rcnt_q <= rcnt_q + 6'h01;
    end
  end

  assign fcnt_nx = fcnt_q + 6'h01;
  always_ff @(negedge shift_clk_in or posedge link_rst_q) begin
    if (link_rst_q) begin
      fcnt_q  <= '0;
      fgray_q <= '0;
    end else if (!chip_select_n_in) begin
      fcnt_q  <= fcnt_nx;
      fgray_q <= fcnt_nx ^ (fcnt_nx >> 1);
    end
  end

  // ------------------------------------------------------------------
  // synchronisers into the system clock
  // ------------------------------------------------------------------
  logic                cs_meta_q;
  logic                cs_sync_q;
  logic [5:0]          fg_meta_q;
  logic [5:0]          fg_sync_q;
  bdsr_mon_s           mon_meta_q;
  bdsr_mon_s           mon_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cs_meta_q  <= 1'b1;
      cs_sync_q  <= 1'b1;
      fg_meta_q  <= '0;
      fg_sync_q  <= '0;
      mon_meta_q <= '0;
      mon_q      <= '0;
    end else begin
      cs_meta_q  <= chip_select_n_in;
      cs_sync_q  <= cs_meta_q;
      fg_meta_q  <= fgray_q;
      fg_sync_q  <= fg_meta_q;
      mon_meta_q <= monitor_in;
      mon_q      <= mon_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------------
  bdsr_state_e         state_q;
  logic [5:0]          rstart_q;
  logic [5:0]          fstart_q;
  logic [5:0]          idx;
  logic [5:0]          edges;
  bdsr_status_s        status;
  bdsr_status_s        snap_q;
  bdsr_hdr_s           hdr_live;
  logic                hdr_valid_q;
  bdsr_data_t          payload_q;
  bdsr_data_t          pay_live;
  bdsr_data_t          pay;
  logic [15:0]         tx_word;
  bdsr_word_s          rx_w;
  bdsr_data_t          regs_q [NUM_REGS];
  bdsr_data_t          set_vec [NUM_REGS];
  logic                is_ro;
  logic                frame_ok;
  logic                bad_frame;
  logic                do_write;
  logic                do_status_clr;
  logic                do_rdclr;

  assign idx      = gray2bin(fg_sync_q) - fstart_q;
  // counts are stable here: select is high, so no edge is taken
  assign edges    = rcnt_q - rstart_q;
  assign rx_w     = bdsr_word_s'(rx_q);
  assign hdr_live = bdsr_hdr_s'(rx_q[HDR_BITS-1:0]);
  assign is_ro    = RO_MAP[rx_w.addr];

  assign frame_ok  = (state_q == ST_COMMIT) && (edges == FRAME_EDGES);
  assign bad_frame = (state_q == ST_COMMIT) && (edges != FRAME_EDGES)
                     && (edges != NO_EDGES);
  assign do_write      = frame_ok && rx_w.wr && !is_ro;
  assign do_status_clr = frame_ok && rx_w.wr;
  assign do_rdclr      = frame_ok && !rx_w.wr && is_ro;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   state_q <= cs_sync_q ? ST_IDLE : ST_ACTIVE;
        ST_ACTIVE: state_q <= cs_sync_q ? ST_COMMIT : ST_ACTIVE;
        ST_COMMIT: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // writes and result registers both show status on write frames
  assign pay_live = hdr_live.wr ? bdsr_data_t'(snap_q[DATA_BITS-1:0])
                                : regs_q[hdr_live.addr];
  assign pay      = hdr_valid_q ? payload_q : pay_live;
  assign tx_word  = {snap_q[STAT_BITS-1:DATA_BITS], pay,
                     ~^{snap_q[STAT_BITS-1:DATA_BITS], pay}};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rstart_q    <= '0;
      fstart_q    <= '0;
      snap_q      <= '0;
      hdr_valid_q <= 1'b0;
      payload_q   <= '0;
    end else if (state_q == ST_IDLE && !cs_sync_q) begin
      rstart_q    <= rcnt_q;
      fstart_q    <= gray2bin(fg_sync_q);
      snap_q      <= status;
      hdr_valid_q <= 1'b0;
    end else if (state_q == ST_ACTIVE && !hdr_valid_q
                 && idx >= HDR_EDGES) begin
      hdr_valid_q <= 1'b1;
      payload_q   <= pay_live;
    end
  end

  // ------------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------------
  logic                so_q;
  logic                so_en_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      so_q    <= 1'b0;
      so_en_q <= 1'b0;
    end else begin
      so_en_q <= !cs_sync_q;
      if (cs_sync_q) begin
        so_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
        so_q <= status.ff;
      end else if (idx < FRAME_EDGES) begin
        so_q <= tx_word[LAST_BIT - idx[3:0]];
      end else begin
        so_q <= 1'b0;
      end
    end
  end

  assign serial_out_out    = so_q;
  assign serial_out_en_out = so_en_q;
  // ------------------------------------------------------------------
  // diagnostics, masks and status
  // ------------------------------------------------------------------
  bdsr_data_t          mask_a;
  bdsr_data_t          mask_b;
  logic                por_q;
  logic                se_q;
  logic                ot_q;
  logic                tw_q;
  logic                vlo_q;
  logic                eto_q;

  assign mask_a = regs_q[ADDR_MASK_A];
  assign mask_b = regs_q[ADDR_MASK_B];
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      set_vec[i] = '0;
    end
    set_vec[ADDR_VRES_PH] = mon_q.verify_phase;
    set_vec[ADDR_VRES_ST] = mon_q.verify_state;
    set_vec[ADDR_FAULT_A] = mon_q.fault_a & ~(mask_a & MASK_DIRECT);
    set_vec[ADDR_FAULT_B] = mon_q.fault_b & ~(mask_b & MASK_DIRECT);
    set_vec[ADDR_FAULT_C] = mon_q.fault_c
      & ~({DATA_BITS{mask_b[MASK_B_VBB]}} & DIAG_SUP_BITS)
      & ~({DATA_BITS{mask_a[MASK_A_BOOT]}} & DIAG_BSU_BITS);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      por_q <= 1'b1;
      se_q  <= 1'b0;
      ot_q  <= 1'b0;
      tw_q  <= 1'b0;
      vlo_q <= 1'b0;
      eto_q <= 1'b0;
    end else begin
      por_q <= por_q && !do_status_clr;
      se_q  <= bad_frame || (se_q && !do_status_clr);
      ot_q  <= mon_q.ot || (ot_q && !do_status_clr);
      tw_q  <= (mon_q.tw && !mask_a[MASK_A_TEMPW])
               || (tw_q && !do_status_clr);
      vlo_q <= (mon_q.vlo && !mask_b[MASK_B_LOGIC])
               || (vlo_q && !do_status_clr);
      eto_q <= mon_q.eto || (eto_q && !do_status_clr);
    end
  end

  always_comb begin
    status     = '0;
    status.por = por_q;
    status.se  = se_q;
    status.ot  = ot_q;
    status.tw  = tw_q;
    status.vs  = |(regs_q[ADDR_FAULT_C] & DIAG_SUP_BITS);
    status.vlo = vlo_q;
    status.eto = eto_q;
    status.vr  = |(regs_q[ADDR_FAULT_B] & DIAG_SUP_BITS);
    status.v3  = |(regs_q[ADDR_FAULT_A] & DIAG_SUP_BITS);
    status.ldf = |(regs_q[ADDR_FAULT_C] & DIAG_LDF_BITS);
    status.bsu = |(regs_q[ADDR_FAULT_C] & DIAG_BSU_BITS);
    status.gsu = |(regs_q[ADDR_FAULT_A] & DIAG_GATE_BITS);
    status.dso = |(regs_q[ADDR_FAULT_B] & DIAG_GATE_BITS);
    status.ff  = |status[STAT_BITS-2:0];
  end

  assign transfer_error_flag_out = se_q;
  // ------------------------------------------------------------------
  // register array
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        regs_q[g] <= REG_RESET[g];
      end else if (RO_MAP[g]) begin
        // a fault arriving while its bit is cleared stays set
        if (do_rdclr && rx_w.addr == 4'(g)) begin
          regs_q[g] <= (regs_q[g] & ~payload_q) | set_vec[g];
        end else begin
          regs_q[g] <= regs_q[g] | set_vec[g];
        end
      end else if (do_write && rx_w.addr == 4'(g)) begin
        regs_q[g] <= rx_w.data;
      end
    end
  end

  assign timing_cfg_out        = bdsr_timing_s'(regs_q[ADDR_TIMING]);
  assign mon_a_cfg_out         = bdsr_mon_a_s'(regs_q[ADDR_MON_A]);
  assign mon_b_cfg_out         = bdsr_mon_b_s'(regs_q[ADDR_MON_B]);
  assign mon_c_cfg_out         = bdsr_mon_c_s'(regs_q[ADDR_MON_C]);
  assign mon_d_cfg_out         = bdsr_mon_d_s'(regs_q[ADDR_MON_D]);
  assign sense_cfg_out         = bdsr_sense_s'(regs_q[ADDR_SENSE]);
  assign verify_cmd_system_out = regs_q[ADDR_VCMD_SYS];
  assign verify_cmd_bridge_out = regs_q[ADDR_VCMD_BRG];
  assign bridge_ctrl_out       = bdsr_ctrl_s'(regs_q[ADDR_CONTROL]);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [3:0]          chk_addr_q;
  always_ff @(posedge clk_in) begin
    chk_addr_q <= rx_w.addr;
  end

  property p_shift_in;
    @(posedge shift_clk_in) disable iff (link_rst_q)
      !chip_select_n_in |=> rx_q[0] == $past(serial_in_in);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial input bit not shifted in");
  property p_hold_deselected;
    @(posedge shift_clk_in) disable iff (link_rst_q)
      chip_select_n_in |=> rcnt_q == $past(rcnt_q) && rx_q == $past(rx_q);
  endproperty
  a_hold_deselected: assert property (p_hold_deselected)
    else $error("shift register moved while deselected");
  property p_release;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_sync_q |=> !serial_out_en_out;
  endproperty
  a_release: assert property (p_release)
    else $error("serial output driven while deselected");
  property p_bad_frame;
    @(posedge clk_in) disable iff (sys_rst_in)
      bad_frame |=> transfer_error_flag_out
        && regs_q[ADDR_CONTROL] == $past(regs_q[ADDR_CONTROL]);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("bad frame not flagged or not discarded");
  property p_error_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      do_status_clr ##1 !bad_frame |-> !transfer_error_flag_out;
  endproperty
  a_error_clear: assert property (p_error_clear)
    else $error("error flag kept after valid write");
  property p_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      do_write |=> regs_q[chk_addr_q] == $past(rx_w.data);
  endproperty
  a_write: assert property (p_write)
    else $error("write data not stored");
  property p_read_nowrite;
    @(posedge clk_in) disable iff (sys_rst_in)
      frame_ok && !rx_w.wr && !is_ro
        |=> regs_q[chk_addr_q] == $past(regs_q[rx_w.addr]);
  endproperty
  a_read_nowrite: assert property (p_read_nowrite)
    else $error("read frame changed a register");
  property p_parity;
    @(posedge clk_in) disable iff (sys_rst_in)
      hdr_valid_q |-> ^{snap_q[STAT_BITS-1:DATA_BITS], payload_q, tx_word[0]};
  endproperty
  a_parity: assert property (p_parity)
    else $error("outgoing word parity not odd");
  property p_ff_first;
    @(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_IDLE && !cs_sync_q
        |=> serial_out_out == $past(status.ff) && serial_out_en_out;
  endproperty
  a_ff_first: assert property (p_ff_first)
    else $error("fault summary not shown at select");
  property p_read_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      do_rdclr && set_vec[rx_w.addr] == '0
        |=> (regs_q[chk_addr_q] & $past(payload_q)) == '0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read-only register not cleared after read");

endmodule // bdsr_serial_regs

// ==== core/bdsr_pkg.sv ====
// package: constants and carriers for the bridge driver serial registers
package bdsr_pkg;

  // ------------------------------------------------------------------
  // word and counter geometry
  // ------------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned DATA_BITS   = 10;
  localparam int unsigned STAT_BITS   = 15;
  localparam int unsigned HDR_BITS    = 5;
  localparam int unsigned CNT_BITS    = 6;
  localparam int unsigned NUM_REGS    = 16;
  localparam logic [5:0]  FRAME_EDGES = 6'h10;
  localparam logic [5:0]  HDR_EDGES   = 6'h05;
  localparam logic [5:0]  NO_EDGES    = 6'h00;
  localparam logic [3:0]  LAST_BIT    = 4'hf;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_TIMING   = 4'h0;
  localparam logic [3:0] ADDR_MON_A    = 4'h1;
  localparam logic [3:0] ADDR_MON_B    = 4'h2;
  localparam logic [3:0] ADDR_MON_C    = 4'h3;
  localparam logic [3:0] ADDR_MON_D    = 4'h4;
  localparam logic [3:0] ADDR_SENSE    = 4'h5;
  localparam logic [3:0] ADDR_VCMD_SYS = 4'h6;
  localparam logic [3:0] ADDR_VCMD_BRG = 4'h7;
  localparam logic [3:0] ADDR_VRES_PH  = 4'h8;
  localparam logic [3:0] ADDR_VRES_ST  = 4'h9;
  localparam logic [3:0] ADDR_MASK_A   = 4'ha;
  localparam logic [3:0] ADDR_MASK_B   = 4'hb;
  localparam logic [3:0] ADDR_FAULT_A  = 4'hc;
  localparam logic [3:0] ADDR_FAULT_B  = 4'hd;
  localparam logic [3:0] ADDR_FAULT_C  = 4'he;
  localparam logic [3:0] ADDR_CONTROL  = 4'hf;
  // read-only (result and report) addresses
  localparam logic [15:0] RO_MAP = 16'h7300;

  // ------------------------------------------------------------------
  // reset values and diagnostic groupings
  // ------------------------------------------------------------------
  typedef logic [9:0] bdsr_data_t;
  localparam bdsr_data_t RST_ZERO    = 10'h000;
  localparam bdsr_data_t RST_TIMING  = 10'h3e0;
  localparam bdsr_data_t RST_MON_A   = 10'h258;
  localparam bdsr_data_t RST_MON_B   = 10'h018;
  localparam bdsr_data_t RST_MON_C   = 10'h210;
  localparam bdsr_data_t RST_MON_D   = 10'h060;
  localparam bdsr_data_t RST_SENSE   = 10'h0f5;
  localparam bdsr_data_t RST_CONTROL = 10'h040;
  localparam logic [15:0][9:0] REG_RESET = {
    RST_CONTROL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_SENSE, RST_MON_D,
    RST_MON_C, RST_MON_B, RST_MON_A, RST_TIMING};

  localparam bdsr_data_t MASK_DIRECT   = 10'h30f;
  localparam bdsr_data_t DIAG_SUP_BITS = 10'h300;
  localparam bdsr_data_t DIAG_GATE_BITS = 10'h00f;
  localparam bdsr_data_t DIAG_BSU_BITS = 10'h060;
  localparam bdsr_data_t DIAG_LDF_BITS = 10'h007;
  localparam int unsigned MASK_A_BOOT  = 7;
  localparam int unsigned MASK_A_TEMPW = 6;
  localparam int unsigned MASK_B_VBB   = 7;
  localparam int unsigned MASK_B_LOGIC = 6;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    bdsr_data_t data;
    logic       parity;
  } bdsr_word_s;

  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
  } bdsr_hdr_s;

  typedef struct packed {
    logic ff, por, se, rsv, ot, tw, vs, vlo, eto, vr, v3, ldf, bsu, gsu,
          dso;
  } bdsr_status_s;

  typedef struct packed {
    logic [3:0] overcurrent_verify_time;
    logic [5:0] dead_time_count;
  } bdsr_timing_s;

  typedef struct packed {
    logic [3:0] overcurrent_threshold;
    logic [5:0] low_side_vds_threshold;
  } bdsr_mon_a_s;

  typedef struct packed {
    logic       overcurrent_qualifier_mode;
    logic       vds_qualifier_mode;
    logic [1:0] bridge_disconnect_threshold;
    logic [5:0] high_side_vds_threshold;
  } bdsr_mon_b_s;

  typedef struct packed {
    logic [3:0] openload_threshold;
    logic [5:0] vds_verify_time;
  } bdsr_mon_c_s;

  typedef struct packed {
    logic       on_state_openload_enable;
    logic       enable_watchdog_on;
    logic       openload_current_select;
    logic       gate_drive_voltage_select;
    logic [5:0] phase_compare_threshold;
  } bdsr_mon_d_s;

  typedef struct packed {
    logic       rsv_hi;
    logic       off_state_openload_disable;
    logic [3:0] sense_amp_offset;
    logic       rsv_lo;
    logic [2:0] sense_amp_gain;
  } bdsr_sense_s;

  typedef struct packed {
    logic [1:0] diag_pin_source;
    logic       bootstrap_mgmt_disable;
    logic       short_fault_action;
    logic [1:0] rsv;
    logic       phase_b_high_gate;
    logic       phase_b_low_gate;
    logic       phase_a_high_gate;
    logic       phase_a_low_gate;
  } bdsr_ctrl_s;

  typedef struct packed {
    bdsr_data_t fault_a;
    bdsr_data_t fault_b;
    bdsr_data_t fault_c;
    bdsr_data_t verify_phase;
    bdsr_data_t verify_state;
    logic       ot;
    logic       tw;
    logic       vlo;
    logic       eto;
  } bdsr_mon_s;

endpackage

// ==== testbench/bdsr_spi_master.sv ====
// partner: serial bus master that frames and clocks transfers
`timescale 1ns/1ns
module bdsr_spi_master (
  output logic      shift_clk_out,
  output logic      chip_select_n_out,
  output logic      serial_in_out,
  input  wire logic serial_out_in
);
  logic ff_q;
  initial begin
    shift_clk_out = 1'b0;
    chip_select_n_out = 1'b1;
    serial_in_out = 1'b0;
    ff_q = 1'b0;
  end
  // n rising edges, msb first, clock idles low between frames
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n_out = 1'b0;
    #64;
    ff_q = serial_out_in;
    for (int i = 0; i < n; i++) begin
      serial_in_out = w[15 - (i % 16)];
      #62;
      shift_clk_out = 1'b1;
      rx = {rx[14:0], serial_out_in};
      #63;
      shift_clk_out = 1'b0;
    end
    #63;
    chip_select_n_out = 1'b1;
    serial_in_out = ~serial_in_out;
    #200;
  endtask
  task automatic idle_clk(input int n);
    for (int i = 0; i < n; i++) begin
      #62;
      shift_clk_out = 1'b1;
      serial_in_out = ~serial_in_out;
      #63;
      shift_clk_out = 1'b0;
    end
  endtask
endmodule // bdsr_spi_master

// ==== testbench/tb.sv ====
// testbench: register access over the serial link with expected values
`timescale 1ns/1ns
module tb;
  import bdsr_pkg::*;
  logic         clk_in, sys_rst_in, sck, csn, serial_in, so, so_en, err;
  logic         last_so, sdo_w;
  bdsr_mon_s    mon, v;
  bdsr_timing_s tcfg;
  bdsr_ctrl_s   ctrl;
  bdsr_data_t   cfg [7];
  logic [15:0]  rx;
  int           n_mismatch, n_compared;

  bdsr_serial_regs dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .shift_clk_in(sck), .chip_select_n_in(csn), .serial_in_in(serial_in),
    .monitor_in(mon), .serial_out_out(so), .serial_out_en_out(so_en),
    .transfer_error_flag_out(err), .timing_cfg_out(tcfg),
    .mon_a_cfg_out(cfg[0]), .mon_b_cfg_out(cfg[1]),
    .mon_c_cfg_out(cfg[2]), .mon_d_cfg_out(cfg[3]),
    .sense_cfg_out(cfg[4]), .verify_cmd_system_out(cfg[5]),
    .verify_cmd_bridge_out(cfg[6]), .bridge_ctrl_out(ctrl));
  bdsr_spi_master m_u (.shift_clk_out(sck), .chip_select_n_out(csn),
    .serial_in_out(serial_in), .serial_out_in(sdo_w));

  // released line shows the inverse of its last driven level
  assign sdo_w = so_en ? so : ~last_so;
  always @(posedge clk_in) if (so_en) last_so <= so;
  always #4 clk_in = ~clk_in;

  function automatic logic [15:0] mk(input logic [3:0] a, input logic wr,
                                     input bdsr_data_t d);
    return {a, wr, d, ~^{a, wr, d}};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input bdsr_data_t d);
    m_u.xfer(mk(a, 1'b0, 10'h000), 16, rx);
    chk(rx[10:1], d, "read data");
    chk(^rx, 1'b1, "out parity");
  endtask
  task automatic set_mon(input bdsr_mon_s s);
    @(posedge clk_in);
    #1 mon = s;
    repeat (6) @(posedge clk_in);
    #1 mon = '0;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    mon = '0;
    last_so = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    m_u.idle_clk(20);
    chk(so_en, 1'b0, "out enable idle");
    chk(tcfg, RST_TIMING, "idle clocks");
    chk(err, 1'b0, "idle clocks flag");
    m_u.xfer(16'hffff, 0, rx);
    chk(m_u.ff_q, 1'b1, "fault flag on select");
    chk(err, 1'b0, "poll flag");
    $display("test select done");
    for (int a = 0; a < 16; a++) begin
      rdchk(a[3:0], REG_RESET[a]);
      chk(rx[15:11], 5'b11000, "status head read");
    end
    $display("test reset read done");
    for (int a = 0; a < 16; a++) if (!RO_MAP[a]) begin
      m_u.xfer(mk(a[3:0], 1'b1, 10'h1c3), 16, rx);
      chk(rx[15:1], {a == 0, a == 0, 13'h0000}, "write status");
    end
    for (int a = 0; a < 16; a++) if (!RO_MAP[a]) rdchk(a[3:0], 10'h1c3);
    chk(tcfg, 10'h1c3, "timing out");
    chk(ctrl, 10'h1c3, "control out");
    for (int i = 0; i < 7; i++) chk(cfg[i], 10'h1c3, "config out");
    $display("test write done");
    for (int n = 8; n < 26; n += 9) begin
      m_u.xfer(mk(4'hf, 1'b1, 10'h000), n, rx);
      chk(err, 1'b1, "bad count flag");
      rdchk(4'hf, 10'h1c3);
      chk(rx[13], 1'b1, "error in status");
      chk(err, 1'b1, "flag after read");
      m_u.xfer(mk(4'hf, 1'b1, 10'h1c3), 16, rx);
      chk(err, 1'b0, "flag after write");
    end
    $display("test framing done");
    m_u.xfer(mk(4'hb, 1'b1, 10'h000), 16, rx);
    v = '0;
    v.fault_b = 10'h002;
    set_mon(v);
    m_u.xfer(mk(4'hd, 1'b1, 10'h3ff), 16, rx);
    chk(rx[10:1], 10'h001, "status on ro write");
    rdchk(4'hd, 10'h002);
    rdchk(4'hd, 10'h000);
    v = '0;
    v.verify_phase = 10'h031;
    set_mon(v);
    rdchk(4'h8, 10'h031);
    rdchk(4'h8, 10'h000);
    $display("test read only done");
    m_u.xfer(mk(4'hb, 1'b1, 10'h001), 16, rx);
    v = '0;
    v.fault_b = 10'h001;
    set_mon(v);
    rdchk(4'hd, 10'h000);
    $display("test mask done");
    wrap_up();
  end
endmodule // tb
